// ==== hdl/adcsc_config.v ====
// startup, calibration and output-link configuration sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adcsc_regs.vh"

// Operation
// - Link enable 0 halts link machine; output settings change only while halted.
// - Calibration enable 0 halts calibration machine; calibration settings change only then.
// - Sync source selects single-ended sync pin or differential timestamp pin.
// - Calibration enable 1 restarts the calibration machine.
// - Link enable 1 starts link so the receiver can initialise.
// - Asserted selected sync starts strobe or user pattern on output buses.
// - Soft trigger 0-to-1 transition starts a calibration.
// - Dual-edge sampling 1 selects single-channel double rate, 0 dual-channel.
// - Demux select 1 spreads output data across four buses.
// - Alignment select 0 gives staggered output data across buses.
module adcsc_config #(
	parameter integer LINK_INIT_CYC = `ADCSC_LINK_INIT_CYC,
	parameter integer CAL_RUN_CYC   = `ADCSC_CAL_RUN_CYC
) (
	// clock and reset
	input  wire                       ref_clk,
	input  wire                       rst,
	// machine enables
	input  wire                       output_link_enable,
	input  wire                       calibration_enable,
	input  wire                       calibration_soft_trigger,
	// output settings
	input  wire [`ADCSC_MODE_W-1:0]   output_mode_select,
	input  wire                       sync_source_select,
	input  wire                       pattern_select,
	input  wire                       dual_edge_sampling_enable,
	input  wire                       output_demux_select,
	input  wire                       output_alignment_select,
	// calibration and overrange settings
	input  wire                       cal_background_mode,
	input  wire                       offset_cal_enable,
	input  wire                       overrange_enable,
	input  wire [`ADCSC_OVR_W-1:0]    overrange_threshold,
	// sync pins
	input  wire                       single_ended_sync_input,
	input  wire                       differential_timestamp_input,
	// link state
	output reg                        link_halted,
	output reg                        link_training,
	output reg                        link_running,
	output reg                        strobe_active,
	output reg                        pattern_active,
	// applied output configuration
	output reg  [`ADCSC_MODE_W-1:0]   active_output_mode,
	output reg                        active_sync_source,
	output reg                        single_channel_mode,
	output reg  [`ADCSC_BUS_W-1:0]    active_buses,
	output reg                        staggered_output,
	// calibration state
	output reg                        cal_halted,
	output reg                        cal_busy,
	output reg                        cal_background_active,
	output reg                        offset_cal_active,
	output reg                        cal_start,
	output reg                        cal_done,
	// overrange
	output reg                        overrange_active,
	output reg  [`ADCSC_OVR_W-1:0]    active_overrange_threshold
);

	// ------------------------------------------------------------
	// one-hot states
	// ------------------------------------------------------------
	localparam [2:0] LNK_HALT  = 3'b001;
	localparam [2:0] LNK_TRAIN = 3'b010;
	localparam [2:0] LNK_RUN   = 3'b100;
	localparam [2:0] CAL_HALT  = 3'b001;
	localparam [2:0] CAL_IDLE  = 3'b010;
	localparam [2:0] CAL_RUN   = 3'b100;

	// last count of each window, cut to the counter width on purpose
	localparam integer            LINK_LAST_I = LINK_INIT_CYC - 1;
	localparam integer            CAL_LAST_I  = CAL_RUN_CYC - 1;
	localparam [`ADCSC_CNT_W-1:0] LINK_LAST   = LINK_LAST_I[`ADCSC_CNT_W-1:0];
	localparam [`ADCSC_CNT_W-1:0] CAL_LAST    = CAL_LAST_I[`ADCSC_CNT_W-1:0];

	reg  [2:0]              link_state;
	reg  [2:0]              next_link_state;
	reg  [2:0]              cal_state;
	reg  [2:0]              next_cal_state;
	reg  [`ADCSC_CNT_W-1:0] link_count;
	reg  [`ADCSC_CNT_W-1:0] cal_count;
	reg                     trig_prev;
	reg                     cal_en_prev;
	wire                    se_sync_level;
	wire                    ts_sync_level;
	wire                    sync_level;
	wire                    trig_rise;
	wire                    cal_restart;

	// bus mask for a demux setting
	function [`ADCSC_BUS_W-1:0] bus_mask;
		input demux;
		begin
			bus_mask = demux ? `ADCSC_BUS_FOUR : `ADCSC_BUS_TWO;
		end
	endfunction

	// ------------------------------------------------------------
	// sync pin capture
	// ------------------------------------------------------------
	adcsc_pin_sync u_se_sync (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.pin_in    (single_ended_sync_input),
		.level_out (se_sync_level)
	);

	adcsc_pin_sync u_ts_sync (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.pin_in    (differential_timestamp_input),
		.level_out (ts_sync_level)
	);

	// source chosen by the applied select
	assign sync_level = (active_sync_source == `ADCSC_SYNC_TS) ? ts_sync_level : se_sync_level;

	// trigger edge and enable restart
	assign trig_rise   = calibration_soft_trigger & ~trig_prev;
	assign cal_restart = calibration_enable & ~cal_en_prev;

	// ------------------------------------------------------------
	// link machine next state
	// ------------------------------------------------------------
	always @* begin
		next_link_state = link_state;
		case (link_state)
			LNK_HALT: begin
				if (output_link_enable) begin
					next_link_state = LNK_TRAIN;
				end
			end
			LNK_TRAIN: begin
				if (!output_link_enable) begin
					next_link_state = LNK_HALT;
				end else if (link_count == LINK_LAST) begin
					next_link_state = LNK_RUN;
				end
			end
			LNK_RUN: begin
				if (!output_link_enable) begin
					next_link_state = LNK_HALT;
				end
			end
			default: begin
				next_link_state = LNK_HALT;
			end
		endcase
	end

	// ------------------------------------------------------------
	// calibration machine next state
	// ------------------------------------------------------------
	always @* begin
		next_cal_state = cal_state;
		case (cal_state)
			CAL_HALT: begin
				if (calibration_enable) begin
					next_cal_state = CAL_RUN;
				end
			end
			CAL_IDLE: begin
				if (!calibration_enable) begin
					next_cal_state = CAL_HALT;
				end else if (trig_rise) begin
					next_cal_state = CAL_RUN;
				end
			end
			CAL_RUN: begin
				if (!calibration_enable) begin
					next_cal_state = CAL_HALT;
				end else if (cal_count == CAL_LAST) begin
					next_cal_state = CAL_IDLE;
				end
			end
			default: begin
				next_cal_state = CAL_HALT;
			end
		endcase
	end

	// ------------------------------------------------------------
	// link machine, output settings and sync response
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (rst) begin
			link_state          <= LNK_HALT;
			link_count          <= {`ADCSC_CNT_W{1'b0}};
			link_halted         <= 1'b1;
			link_training       <= 1'b0;
			link_running        <= 1'b0;
			strobe_active       <= 1'b0;
			pattern_active      <= 1'b0;
			active_output_mode  <= `ADCSC_MODE_RST;
			active_sync_source  <= `ADCSC_SYNC_SE;
			single_channel_mode <= 1'b0;
			active_buses        <= `ADCSC_BUS_TWO;
			staggered_output    <= 1'b1;
		end else begin
			link_state    <= next_link_state;
			link_halted   <= next_link_state[0];
			link_training <= next_link_state[1];
			link_running  <= next_link_state[2];
			// training window count
			if (link_state == LNK_TRAIN) begin
				link_count <= link_count + 1'b1;
			end else begin
				link_count <= {`ADCSC_CNT_W{1'b0}};
			end
			// output settings follow the inputs only while halted
			if (link_state == LNK_HALT) begin
				active_output_mode  <= output_mode_select;
				active_sync_source  <= sync_source_select;
				single_channel_mode <= dual_edge_sampling_enable;
				active_buses        <= bus_mask(output_demux_select);
				staggered_output    <= ~output_alignment_select;
			end
			// strobe or pattern while sync is held on a running link
			if (next_link_state == LNK_RUN && sync_level) begin
				strobe_active  <= ~pattern_select;
				pattern_active <= pattern_select;
			end else begin
				strobe_active  <= 1'b0;
				pattern_active <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// calibration machine, calibration and overrange settings
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (rst) begin
			cal_state                  <= CAL_HALT;
			cal_count                  <= {`ADCSC_CNT_W{1'b0}};
			trig_prev                  <= 1'b0;
			cal_en_prev                <= 1'b0;
			cal_halted                 <= 1'b1;
			cal_busy                   <= 1'b0;
			cal_start                  <= 1'b0;
			cal_done                   <= 1'b0;
			cal_background_active      <= 1'b0;
			offset_cal_active          <= 1'b0;
			overrange_active           <= 1'b0;
			active_overrange_threshold <= `ADCSC_OVR_RST;
		end else begin
			cal_state   <= next_cal_state;
			trig_prev   <= calibration_soft_trigger;
			cal_en_prev <= calibration_enable;
			cal_halted  <= next_cal_state[0];
			cal_busy    <= next_cal_state[2];
			// one-cycle start pulse on entry to a run
			cal_start <= next_cal_state[2] & ~cal_state[2];
			// done pulse when a run completes
			cal_done <= cal_state[2] & next_cal_state[1];
			if (cal_state == CAL_RUN && !cal_restart) begin
				cal_count <= cal_count + 1'b1;
			end else begin
				cal_count <= {`ADCSC_CNT_W{1'b0}};
			end
			// calibration choices latch only while halted
			if (cal_state == CAL_HALT) begin
				cal_background_active <= cal_background_mode;
				offset_cal_active     <= offset_cal_enable;
			end
			// overrange detection usable once calibration is enabled
			overrange_active <= overrange_enable & ~next_cal_state[0];
			if (overrange_enable) begin
				active_overrange_threshold <= overrange_threshold;
			end
		end
	end

endmodule // adcsc_config

`default_nettype wire

// ==== shared/adcsc_regs.vh ====
// constants for the converter startup and alignment configuration block
`ifndef ADCSC_REGS_VH
`define ADCSC_REGS_VH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define ADCSC_CLK_PERIOD_NS     100

// ----------------------------------------------------------------
// timing: link receiver training window, calibration run length
// ----------------------------------------------------------------
`define ADCSC_LINK_INIT_NS      1600
`define ADCSC_LINK_INIT_CYC     ((`ADCSC_LINK_INIT_NS + `ADCSC_CLK_PERIOD_NS - 1) / `ADCSC_CLK_PERIOD_NS)
`define ADCSC_CAL_RUN_US        100
`define ADCSC_CAL_RUN_CYC       ((`ADCSC_CAL_RUN_US * 1000 + `ADCSC_CLK_PERIOD_NS - 1) / `ADCSC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------
`define ADCSC_MODE_W            3
`define ADCSC_MODE_RST          3'h0
`define ADCSC_OVR_W             8
`define ADCSC_OVR_RST           8'h00
`define ADCSC_BUS_W             4
`define ADCSC_BUS_FOUR          4'hF
`define ADCSC_BUS_TWO           4'h3
`define ADCSC_SYNC_SE           1'b0
`define ADCSC_SYNC_TS           1'b1
`define ADCSC_CNT_W             12

`endif

// ==== hdl/adcsc_pin_sync.v ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module adcsc_pin_sync (
	// clock and reset
	input  wire ref_clk,
	input  wire rst,
	// pin and synchronised level
	input  wire pin_in,
	output reg  level_out
);

	reg stage1;
	reg stage2;
	reg stage3;

	// ------------------------------------------------------------
	// capture chain; stage1 feeds only stage2
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (rst) begin
			stage1    <= 1'b0;
			stage2    <= 1'b0;
			stage3    <= 1'b0;
			level_out <= 1'b0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				level_out <= stage3; // change counts once two stages agree
			end
		end
	end

endmodule // adcsc_pin_sync

`default_nettype wire

// ==== dv/adcsc_config_chk.sv ====
// port assertions for the startup and alignment configuration block
`timescale 1ns/100ps
`default_nettype none
module adcsc_config_chk #(
	parameter integer LINK_INIT_CYC = 16,
	parameter integer CAL_RUN_CYC   = 1000
) (
	// clock, reset and enables
	input wire logic       ref_clk, rst, output_link_enable, calibration_enable, calibration_soft_trigger,
	// settings and pins
	input wire logic [2:0] output_mode_select,
	input wire logic       sync_source_select, pattern_select, dual_edge_sampling_enable, output_demux_select,
	input wire logic       output_alignment_select, overrange_enable,
	input wire logic       single_ended_sync_input, differential_timestamp_input,
	input wire logic [7:0] overrange_threshold, active_overrange_threshold,
	// state and applied configuration
	input wire logic       link_halted, link_training, link_running, strobe_active, pattern_active,
	input wire logic [2:0] active_output_mode,
	input wire logic [3:0] active_buses,
	input wire logic       active_sync_source, single_channel_mode, staggered_output,
	input wire logic       cal_halted, cal_busy, cal_start, cal_done,
	input wire logic       cal_background_active, offset_cal_active
);
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	// raw level of whichever sync pin is selected
	wire sel_pin = active_sync_source ? differential_timestamp_input : single_ended_sync_input;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_train;
		$rose(link_training);
	endsequence
	sequence s_cal_run;
		cal_start ##1 (calibration_enable && !$rose(calibration_enable))[*3];
	endsequence
	sequence s_sync_held;
		(link_running && sel_pin && $stable(pattern_select))[*6];
	endsequence

	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	a_link_halt: assert property (!output_link_enable |=> link_halted)
		else $error("link not halted after disable");
	a_cal_halt: assert property (!calibration_enable |=> cal_halted)
		else $error("calibration not halted after disable");
	a_cal_cfg_hold: assert property (!cal_halted |=> $stable({cal_background_active, offset_cal_active}))
		else $error("calibration setting changed while calibration enabled");
	a_cfg_hold: assert property (!link_halted && output_link_enable |=>
		$stable({active_output_mode, active_buses, single_channel_mode, staggered_output, active_sync_source}))
		else $error("output setting changed while link active");
	a_cfg_apply: assert property (link_halted && $past(link_halted) && !$past(rst) |->
		{active_output_mode, single_channel_mode, active_buses, staggered_output, active_sync_source} ==
		{$past(output_mode_select), $past(dual_edge_sampling_enable), ($past(output_demux_select) ? 4'hF : 4'h3),
		!$past(output_alignment_select), $past(sync_source_select)})
		else $error("halted settings not applied");
	a_link_start: assert property ($rose(output_link_enable) |=> link_training)
		else $error("link training did not start");
	a_link_ready: assert property (s_train ##1 (output_link_enable && !link_running) ##1 output_link_enable
		|-> link_running)
		else $error("link running at wrong time");
	a_cal_begin: assert property (($rose(calibration_enable) || ($rose(calibration_soft_trigger) &&
		calibration_enable && !cal_busy && !cal_halted)) |=> cal_start && cal_busy)
		else $error("calibration run did not start");
	a_cal_run: assert property (s_cal_run |=> cal_done && !cal_busy)
		else $error("calibration run length wrong");
	a_trig_refused: assert property ($rose(calibration_soft_trigger) && cal_busy &&
		!$rose(calibration_enable) |=> !cal_start)
		else $error("trigger accepted while busy");
	a_sync_out: assert property (s_sync_held |-> pattern_active == pattern_select &&
		strobe_active == !pattern_select)
		else $error("strobe or pattern missing after sync");
	a_ovr_capture: assert property (overrange_enable |=> active_overrange_threshold == $past(overrange_threshold))
		else $error("overrange threshold not captured");
endmodule // adcsc_config_chk
`default_nettype wire

// ==== dv/adcsc_host.sv ====
// host model that programs the block in startup order
`timescale 1ns/100ps
`default_nettype none
module adcsc_host (
	// clock, reset and request
	input  wire logic ref_clk, rst, start, trig_late,
	// sequence state and enables into the block
	output var  logic busy = 1'b0, output_link_enable = 1'b0, calibration_enable = 1'b0,
	output var  logic calibration_soft_trigger = 1'b0, overrange_enable = 1'b0
);
	logic [4:0] step = 5'h0;

	// one step per falling edge; steps 2-3 leave both machines halted for settings
	always @(negedge ref_clk) begin
		if (rst) begin
			{busy, output_link_enable, calibration_enable, calibration_soft_trigger, overrange_enable} <= 5'h0;
			step <= 5'h0;
		end else if (!busy) begin
			busy <= start;
			step <= 5'h0;
		end else begin
			step <= step + 5'h1;
			case (step)
				5'h0: output_link_enable <= 1'b0;
				5'h1: calibration_enable <= 1'b0;
				5'h4: calibration_enable <= 1'b1;
				5'h5: overrange_enable <= 1'b1;
				5'h6: output_link_enable <= 1'b1;
				5'h7: calibration_soft_trigger <= 1'b0;
				5'h8: calibration_soft_trigger <= !trig_late;
				5'hD: calibration_soft_trigger <= 1'b1;
				5'hE: busy <= 1'b0;
				default: ;
			endcase
		end
	end
endmodule // adcsc_host
`default_nettype wire

// ==== dv/adcsc_config_tb.sv ====
// self-checking testbench for the startup configuration block
`timescale 1ns/100ps
`default_nettype none
module adcsc_config_tb;
	// ------------------------------------------------
	// signals
	// ------------------------------------------------
	logic       ref_clk = 1'b0, rst = 1'b1, start = 1'b0, trig_late = 1'b0, busy;
	logic       output_link_enable, calibration_enable, calibration_soft_trigger, overrange_enable;
	logic [2:0] output_mode_select = 3'h0, active_output_mode;
	logic       sync_source_select = 1'b0, pattern_select = 1'b0, dual_edge_sampling_enable = 1'b0;
	logic       output_demux_select = 1'b0, output_alignment_select = 1'b0, cal_background_mode = 1'b0;
	logic       offset_cal_enable = 1'b0, single_ended_sync_input = 1'b0, differential_timestamp_input = 1'b0;
	logic [7:0] overrange_threshold = 8'h00, active_overrange_threshold;
	logic       link_halted, link_training, link_running, strobe_active, pattern_active, active_sync_source;
	logic       single_channel_mode, staggered_output, cal_halted, cal_busy, cal_background_active;
	logic       offset_cal_active, cal_start, cal_done, overrange_active;
	logic [3:0] active_buses;
	int         n_fail = 0, n_compared = 0, n_starts = 0;
	typedef struct packed {logic [2:0] mode; logic des, demux, align, sync, pat; logic [3:0] buses; logic stag;} adcsc_row_t;
	// settings beside the bus mask and stagger they should give
	adcsc_row_t rows [4] = '{'{3'h5, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'hF, 1'b1},
		'{3'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1},
		'{3'h7, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'h3, 1'b0},
		'{3'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 4'h3, 1'b0}};

	adcsc_config #(.LINK_INIT_CYC(2), .CAL_RUN_CYC(4)) dut_u (.*);
	adcsc_host host_u (.*);

	// clock and run-start counter
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (cal_start) n_starts++;

	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic run_host();
		@(negedge ref_clk) start <= 1'b1;
		@(negedge ref_clk) start <= 1'b0;
		repeat (40) @(posedge ref_clk) if (!busy) break;
		repeat (8) @(negedge ref_clk);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		repeat (2) @(negedge ref_clk);
		rst <= 1'b0;
		check("reset halt", 8'h03, {6'h0, link_halted, cal_halted});
		foreach (rows[k]) begin
			@(negedge ref_clk);
			{output_mode_select, dual_edge_sampling_enable, output_demux_select} <= {rows[k].mode, rows[k].des, rows[k].demux};
			{output_alignment_select, sync_source_select, pattern_select} <= {rows[k].align, rows[k].sync, rows[k].pat};
			{trig_late, overrange_threshold, n_starts} <= {rows[k].pat, 8'h30 + 8'(k), 32'h0000_0000};
			{cal_background_mode, offset_cal_enable} <= {rows[k].des, rows[k].align};
			repeat (3) @(negedge ref_clk);
			if (k > 0) check("held mode", 8'(rows[k-1].mode), 8'(active_output_mode));
			if (k > 0) check("held background", 8'(rows[k-1].des), 8'(cal_background_active));
			run_host();
			check("mode", 8'(rows[k].mode), 8'(active_output_mode));
			check("single channel", 8'(rows[k].des), 8'(single_channel_mode));
			check("buses", 8'(rows[k].buses), 8'(active_buses));
			check("staggered", 8'(rows[k].stag), 8'(staggered_output));
			check("sync source", 8'(rows[k].sync), 8'(active_sync_source));
			check("running", 8'h01, 8'(link_running));
			check("overrange", 8'h01, {7'h00, overrange_active});
			check("background cal", 8'(rows[k].des), 8'(cal_background_active));
			check("offset cal", 8'(rows[k].align), 8'(offset_cal_active));
			check("threshold", 8'h30 + 8'(k), active_overrange_threshold);
			check("cal starts", 8'(rows[k].pat) + 8'h01, 8'(n_starts));
			{differential_timestamp_input, single_ended_sync_input} <= {rows[k].sync, !rows[k].sync};
			repeat (7) @(negedge ref_clk);
			check("sync outputs", {6'h0, !rows[k].pat, rows[k].pat}, {6'h0, strobe_active, pattern_active});
			{differential_timestamp_input, single_ended_sync_input} <= 2'h0;
			repeat (7) @(negedge ref_clk);
			check("sync idle", 8'h00, {6'h0, strobe_active, pattern_active});
			$display("row %0d done", k);
		end
		// reset in mid-sequence, then program again from scratch
		@(negedge ref_clk) start <= 1'b1;
		@(negedge ref_clk) start <= 1'b0;
		repeat (6) @(negedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(negedge ref_clk);
		check("reset again", 8'h13, {3'h0, staggered_output, active_buses[3:2], link_halted, cal_halted});
		rst <= 1'b0;
		@(negedge ref_clk);
		check("reset settle", {3'h0, rows[3].stag, rows[3].buses[3:2], 2'b11},
			{3'h0, staggered_output, active_buses[3:2], link_halted, cal_halted});
		run_host();
		check("running again", 8'h01, 8'(link_running));
		$display("reset test done");
		tally_and_finish();
	end

	// watchdog sized well beyond the expected few hundred cycles
	initial begin
		repeat (2000) @(posedge ref_clk);
		n_fail++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule // adcsc_config_tb
bind adcsc_config adcsc_config_chk #(.LINK_INIT_CYC(LINK_INIT_CYC), .CAL_RUN_CYC(CAL_RUN_CYC)) chk_u (.*);
`default_nettype wire
